// *** src/bpc_pkg.sv ***
// constants for the bus port control block
package bpc_pkg;
	// ---------------- register offsets ----------------
	localparam logic [7:0] OFS_HIGH_DATA = 8'h00;
	localparam logic [7:0] OFS_LOW_DATA = 8'h04;
	localparam logic [7:0] OFS_HIGH_DIR = 8'h08;
	localparam logic [7:0] OFS_LOW_DIR = 8'h0C;
	localparam logic [7:0] OFS_CTRL_DATA = 8'h10;
	localparam logic [7:0] OFS_CTRL_DIR = 8'h14;
	localparam logic [7:0] OFS_FSEL = 8'h18;
	localparam logic [7:0] OFS_MODE = 8'h1C;
	// ---------------- mode strap codes ----------------
	localparam logic [2:0] MD_SPEC_SINGLE = 3'h0;
	localparam logic [2:0] MD_SPEC_EXP_NARROW = 3'h1;
	localparam logic [2:0] MD_PERIPH = 3'h2;
	localparam logic [2:0] MD_SPEC_EXP_WIDE = 3'h3;
	localparam logic [2:0] MD_NORM_SINGLE = 3'h4;
	localparam logic [2:0] MD_NORM_EXP_NARROW = 3'h5;
	localparam logic [2:0] MD_NORM_EXP_WIDE = 3'h7;
	// ---------------- function select fields ----------------
	localparam int FS_NO_DBE = 7;
	localparam int FS_QUEUE_EN = 5;
	localparam int FS_NO_BUS_E_CLOCK_OUT = 4;
	localparam int FS_LOW_BYTE_STROBE_N_EN = 3;
	localparam int FS_RDW_EN = 2;
	localparam logic [7:0] FS_RST_NORM_SINGLE = 8'h90;
	localparam logic [7:0] FS_RST_SPEC_SINGLE = 8'h80;
	localparam logic [7:0] FS_RST_NORM_EXP = 8'h80;
	localparam logic [7:0] FS_RST_SPEC_EXP = 8'hAC;
	localparam logic [7:0] FS_RST_PERIPH = 8'h90;
	localparam logic [7:0] FS_WRITE_MASK = 8'hBC;
	// ---------------- mode register fields ----------------
	localparam int MR_EMUL = 3;
	localparam int MR_PULLUP = 4;
	// ---------------- reset values and control pin masks ----------------
	localparam logic [7:0] PORT_RST = 8'h00;
	localparam logic [2:0] MODE_RST = MD_NORM_SINGLE;
	localparam logic [7:0] CTRL_INPUT_ONLY = 8'h03;
	localparam logic [7:0] CTRL_PULLUP_SEL = 8'h8E;
	localparam logic [7:0] CTRL_PULLUP_FIX = 8'h01;
endpackage

// *** src/bpc_port_ctrl.sv ***
// bus port control: address/data ports, control port and register map
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module bpc_port_ctrl
	import bpc_pkg::*;
(
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// mode straps and status
	input wire logic [2:0] mode_strap,
	input wire logic [1:0] queue_status,
	// high port pins
	input wire logic [7:0] high_port_pins_in,
	output logic [7:0] high_port_pins_out,
	output logic [7:0] high_port_pins_oe,
	// low port pins
	input wire logic [7:0] low_port_pins_in,
	output logic [7:0] low_port_pins_out,
	output logic [7:0] low_port_pins_oe,
	// control port pins
	input wire logic [7:0] ctrl_port_pins_in,
	output logic [7:0] ctrl_port_pins_out,
	output logic [7:0] ctrl_port_pins_oe,
	output logic [7:0] ctrl_port_pullup,
	// external access requests
	input wire logic ext_req,
	input wire logic [15:0] ext_addr,
	input wire logic ext_write,
	input wire logic ext_word,
	input wire logic ext_int_ram,
	input wire logic [15:0] ext_wdata,
	output logic [15:0] ext_rdata,
	output logic ext_done
);
	typedef enum logic [1:0] {BS_IDLE, BS_ADDR, BS_DATA} bpc_bus_e;

	// ---------------------------------------------
	// mode capture
	// ---------------------------------------------
	logic [2:0] mode;
	logic mode_taken;
	logic is_exp;
	logic is_periph;
	logic is_single;
	logic is_narrow;
	logic is_norm_narrow;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= MODE_RST;
			mode_taken <= 1'b0;
		end else if (!mode_taken) begin
			mode <= mode_strap;
			mode_taken <= 1'b1;
		end
	end

	assign is_periph = (mode == MD_PERIPH);
	assign is_single = (mode == MD_SPEC_SINGLE) || (mode == MD_NORM_SINGLE);
	assign is_exp = !is_periph && !is_single;
	assign is_narrow = (mode == MD_SPEC_EXP_NARROW) || (mode == MD_NORM_EXP_NARROW);
	assign is_norm_narrow = (mode == MD_NORM_EXP_NARROW);

	function automatic logic [7:0] fsel_reset(input logic [2:0] m);
		case (m)
			MD_NORM_SINGLE: fsel_reset = FS_RST_NORM_SINGLE;
			MD_SPEC_SINGLE: fsel_reset = FS_RST_SPEC_SINGLE;
			MD_NORM_EXP_NARROW, MD_NORM_EXP_WIDE: fsel_reset = FS_RST_NORM_EXP;
			MD_SPEC_EXP_NARROW, MD_SPEC_EXP_WIDE: fsel_reset = FS_RST_SPEC_EXP;
			default: fsel_reset = FS_RST_PERIPH;
		endcase
	endfunction

	// ---------------------------------------------
	// register file
	// ---------------------------------------------
	logic [7:0] high_port_data;
	logic [7:0] high_port_direction;
	logic [7:0] low_port_data;
	logic [7:0] low_port_direction;
	logic [7:0] control_port_data;
	logic [7:0] control_port_direction;
	logic [7:0] control_port_function_select;
	logic emulate_control_port;
	logic pullup_en;
	logic ab_present;
	logic ctrl_present;
	logic fs_present;
	logic hit;
	logic [7:0] rd_byte;
	logic [7:0] ctrl_alt;
	logic wr_go;
	logic [7:0] wbyte;

	assign ab_present = !is_exp && !is_periph;
	assign ctrl_present = !is_periph && !(is_exp && emulate_control_port);
	assign fs_present = !is_periph;
	assign wr_go = psel && penable && pready && pwrite && hit && pstrb[0];
	assign wbyte = pwdata[7:0];

	always_comb begin
		hit = 1'b0;
		rd_byte = 8'h00;
		case (paddr)
			OFS_HIGH_DATA: begin
				hit = ab_present;
				rd_byte = (high_port_direction & high_port_data) | (~high_port_direction & high_port_pins_in);
			end
			OFS_LOW_DATA: begin
				hit = ab_present;
				rd_byte = (low_port_direction & low_port_data) | (~low_port_direction & low_port_pins_in);
			end
			OFS_HIGH_DIR: begin
				hit = ab_present;
				rd_byte = high_port_direction;
			end
			OFS_LOW_DIR: begin
				hit = ab_present;
				rd_byte = low_port_direction;
			end
			OFS_CTRL_DATA: begin
				hit = ctrl_present;
				rd_byte = (ctrl_port_pins_oe & control_port_data) | (~ctrl_port_pins_oe & ctrl_port_pins_in);
			end
			OFS_CTRL_DIR: begin
				hit = ctrl_present;
				rd_byte = control_port_direction;
			end
			OFS_FSEL: begin
				hit = fs_present;
				rd_byte = control_port_function_select;
			end
			OFS_MODE: begin
				hit = 1'b1;
				rd_byte = {3'h0, pullup_en, emulate_control_port, mode};
			end
			default: begin
				hit = 1'b0;
				rd_byte = 8'h00;
			end
		endcase
	end

	// apb answer: one wait state, absent or unmapped gives slverr
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= !hit;
			prdata <= (hit && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_port_data <= PORT_RST;
			high_port_direction <= PORT_RST;
			low_port_data <= PORT_RST;
			low_port_direction <= PORT_RST;
		end else if (wr_go) begin
			case (paddr)
				OFS_HIGH_DATA: high_port_data <= wbyte;
				OFS_LOW_DATA: low_port_data <= wbyte;
				OFS_HIGH_DIR: high_port_direction <= wbyte;
				OFS_LOW_DIR: low_port_direction <= wbyte;
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_port_data <= PORT_RST;
			control_port_direction <= PORT_RST;
		end else if (wr_go && paddr == OFS_CTRL_DATA) begin
			control_port_data <= wbyte;
		end else if (wr_go && paddr == OFS_CTRL_DIR) begin
			control_port_direction <= wbyte & ~CTRL_INPUT_ONLY;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_port_function_select <= FS_RST_NORM_SINGLE;
		end else if (!mode_taken) begin
			control_port_function_select <= fsel_reset(mode_strap);
		end else if (wr_go && paddr == OFS_FSEL) begin
			control_port_function_select <= wbyte & FS_WRITE_MASK;
			if (is_exp) begin
				control_port_function_select[FS_NO_BUS_E_CLOCK_OUT] <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			emulate_control_port <= 1'b0;
			pullup_en <= 1'b0;
		end else if (wr_go && paddr == OFS_MODE) begin
			emulate_control_port <= wbyte[MR_EMUL];
			pullup_en <= wbyte[MR_PULLUP];
		end
	end

	// ---------------------------------------------
	// external bus sequencer
	// ---------------------------------------------
	bpc_bus_e bus_state;
	logic bus_e_clock_out;
	logic [15:0] cur_addr;
	logic [15:0] cur_data;
	logic cur_word;
	logic cur_write;
	logic split;
	logic half;
	logic take;
	logic [7:0] cur_byte;
	logic [7:0] rd_pin;
	logic drive_addr;
	logic [15:0] pin_addr;
	logic nx_word;
	logic nx_write;
	logic nx_live;

	assign take = (bus_state == BS_IDLE) && ext_req && is_exp && bus_e_clock_out && !ext_done;
	assign cur_byte = half ? cur_data[7:0] : cur_data[15:8];
	assign rd_pin = (is_narrow || !cur_addr[0]) ? high_port_pins_in : low_port_pins_in;
	// pin flops lag a cycle, so pins are fed one state ahead
	assign drive_addr = take || (bus_state == BS_DATA && split && !half);
	assign pin_addr = take ? ext_addr : (drive_addr ? cur_addr + 16'h0001 : cur_addr);
	assign nx_word = take ? (ext_word && !is_narrow && !(ext_addr[0] && !ext_int_ram)) : cur_word;
	assign nx_write = take ? ext_write : cur_write;
	assign nx_live = drive_addr || (bus_state == BS_ADDR);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_e_clock_out <= 1'b0;
		end else begin
			bus_e_clock_out <= !bus_e_clock_out;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_state <= BS_IDLE;
			cur_addr <= 16'h0000;
			cur_data <= 16'h0000;
			cur_word <= 1'b0;
			cur_write <= 1'b0;
			split <= 1'b0;
			half <= 1'b0;
			ext_rdata <= 16'h0000;
			ext_done <= 1'b0;
		end else begin
			ext_done <= 1'b0;
			case (bus_state)
				BS_IDLE: begin
					if (take) begin
						bus_state <= BS_ADDR;
						cur_addr <= ext_addr;
						cur_data <= ext_wdata;
						cur_write <= ext_write;
						// narrow bus or external odd word runs as two byte cycles
						split <= ext_word && (is_narrow || (ext_addr[0] && !ext_int_ram));
						cur_word <= nx_word;
						half <= 1'b0;
					end
				end
				BS_ADDR: bus_state <= BS_DATA;
				BS_DATA: begin
					if (cur_word) begin
						ext_rdata <= cur_addr[0] ? {low_port_pins_in, high_port_pins_in}
							: {high_port_pins_in, low_port_pins_in};
					end else if (!half) begin
						ext_rdata <= {rd_pin, 8'h00};
					end else begin
						ext_rdata[7:0] <= rd_pin;
					end
					if (split && !half) begin
						half <= 1'b1;
						cur_addr <= cur_addr + 16'h0001;
						bus_state <= BS_ADDR;
					end else begin
						ext_done <= 1'b1;
						bus_state <= BS_IDLE;
					end
				end
				default: bus_state <= BS_IDLE;
			endcase
		end
	end

	// ---------------------------------------------
	// pin drive
	// ---------------------------------------------
	logic [7:0] next_hi_out;
	logic [7:0] next_hi_oe;
	logic [7:0] next_lo_out;
	logic [7:0] next_lo_oe;
	logic [7:0] next_ce_out;
	logic [7:0] next_ce_oe;
	logic [7:0] next_pullup;
	logic low_byte_strobe_n_n;

	assign low_byte_strobe_n_n = !(nx_word ^ pin_addr[0]);
	assign ctrl_alt = {
		is_exp && !control_port_function_select[FS_NO_DBE],
		{2{is_exp && control_port_function_select[FS_QUEUE_EN]}},
		!control_port_function_select[FS_NO_BUS_E_CLOCK_OUT],
		is_exp && !is_norm_narrow && control_port_function_select[FS_LOW_BYTE_STROBE_N_EN],
		is_exp && control_port_function_select[FS_RDW_EN],
		2'b00};

	always_comb begin
		next_hi_out = high_port_data;
		next_hi_oe = high_port_direction;
		next_lo_out = low_port_data;
		next_lo_oe = low_port_direction;
		if (is_exp) begin
			next_hi_oe = 8'h00;
			next_lo_oe = 8'h00;
			if (drive_addr) begin
				next_hi_out = pin_addr[15:8];
				next_lo_out = pin_addr[7:0];
				next_hi_oe = 8'hFF;
				next_lo_oe = 8'hFF;
			end else if (bus_state == BS_ADDR && cur_write) begin
				next_hi_oe = 8'hFF;
				next_lo_oe = is_narrow ? 8'h00 : 8'hFF;
				if (cur_word) begin
					next_hi_out = cur_addr[0] ? cur_data[7:0] : cur_data[15:8];
					next_lo_out = cur_addr[0] ? cur_data[15:8] : cur_data[7:0];
				end else begin
					next_hi_out = cur_byte;
					next_lo_out = cur_byte;
				end
			end
			if (is_narrow) begin
				next_lo_out = pin_addr[7:0];
				next_lo_oe = 8'hFF;
			end
		end
	end

	generate
		for (genvar i = 0; i < 8; i++) begin : g_ctrl
			always_comb begin
				if (CTRL_INPUT_ONLY[i]) begin
					next_ce_out[i] = 1'b0;
					next_ce_oe[i] = 1'b0;
				end else if (ctrl_alt[i]) begin
					next_ce_oe[i] = (i != FS_NO_DBE);
					case (i)
						6: next_ce_out[i] = queue_status[1];
						5: next_ce_out[i] = queue_status[0];
						4: next_ce_out[i] = !bus_e_clock_out;
						3: next_ce_out[i] = nx_live ? low_byte_strobe_n_n : 1'b1;
						2: next_ce_out[i] = nx_live ? !nx_write : 1'b1;
						default: next_ce_out[i] = 1'b0;
					endcase
				end else begin
					next_ce_out[i] = control_port_data[i];
					next_ce_oe[i] = control_port_direction[i];
				end
				next_pullup[i] = CTRL_PULLUP_FIX[i] || (CTRL_PULLUP_SEL[i] && pullup_en && !next_ce_oe[i]);
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_port_pins_out <= 8'h00;
			high_port_pins_oe <= 8'h00;
			low_port_pins_out <= 8'h00;
			low_port_pins_oe <= 8'h00;
			ctrl_port_pins_out <= 8'h00;
			ctrl_port_pins_oe <= 8'h00;
			ctrl_port_pullup <= CTRL_PULLUP_FIX;
		end else begin
			high_port_pins_out <= next_hi_out;
			high_port_pins_oe <= next_hi_oe;
			low_port_pins_out <= next_lo_out;
			low_port_pins_oe <= next_lo_oe;
			ctrl_port_pins_out <= next_ce_out;
			ctrl_port_pins_oe <= next_ce_oe;
			ctrl_port_pullup <= next_pullup;
		end
	end
endmodule

// *** tb/bpc_ext_mem.sv ***
// external memory model on the expansion bus
`timescale 1ns/1ps
module bpc_ext_mem (
	// clock
	input wire logic pclk,
	// device side of the address/data pins
	input wire logic [7:0] hi_out,
	input wire logic [7:0] hi_oe,
	input wire logic [7:0] lo_out,
	input wire logic [7:0] lo_oe,
	// resolved pin levels
	output logic [7:0] hi_in,
	output logic [7:0] lo_in
);
	logic [15:0] addr_q = 16'h0000;
	// ----------------------------
	// address latch and read drive
	// ----------------------------
	always_ff @(posedge pclk) begin
		if (hi_oe == 8'hFF && lo_oe == 8'hFF) begin
			addr_q <= {hi_out, lo_out};
		end
	end
	// memory returns a pattern tied to the latched address wherever the device is not driving
	assign hi_in = (hi_oe & hi_out) | (~hi_oe & addr_q[7:0]);
	assign lo_in = (lo_oe & lo_out) | (~lo_oe & ~addr_q[7:0]);
endmodule

// *** tb/bpc_port_ctrl_sva.sv ***
// assertion checker for the bus port control block
`timescale 1ns/1ps
module bpc_port_ctrl_sva (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// control port
	input wire logic [7:0] ctrl_port_pins_oe,
	input wire logic [7:0] ctrl_port_pullup,
	// external access
	input wire logic ext_req,
	input wire logic [15:0] ext_rdata,
	input wire logic ext_done
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ------
	// checks
	// ------
	irq_never_driven_a: assert property (ctrl_port_pins_oe[1:0] == 2'b00)
		else $error("interrupt pin driven");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held past one cycle");
	access_answer_a: assert property (psel && penable && !pready |=> pready)
		else $error("access phase not answered");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	err_data_zero_a: assert property (pslverr |-> prdata == 32'h00000000)
		else $error("refused access returned data");
	upper_bits_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
		else $error("read data above eight bits");
	done_pulse_a: assert property (ext_done |=> !ext_done)
		else $error("done held past one cycle");
	irq_pullup_a: assert property (ctrl_port_pullup[0])
		else $error("interrupt pin pull-up missing");
	no_pullup_mid_a: assert property (ctrl_port_pullup[6:4] == 3'b000)
		else $error("pull-up on queue or clock pin");
	rdata_hold_a: assert property (!ext_req && !$past(ext_req) |-> $stable(ext_rdata))
		else $error("read result changed while idle");
	cover property (pready && pslverr);
	cover property (pready && !pslverr);
	cover property (ext_done);
endmodule

bind bpc_port_ctrl bpc_port_ctrl_sva chk_i (.pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr,
	.ctrl_port_pins_oe, .ctrl_port_pullup, .ext_req, .ext_rdata, .ext_done);

// *** tb/tb_top.sv ***
// self-checking bench for the bus port control block
`timescale 1ns/1ps
module tb_top;
	import bpc_pkg::*;
	// -------
	// signals
	// -------
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ext_req = 0, ext_write = 0, err_q, seen_a, seen_d;
	logic [7:0] paddr = 8'h00, ctrl_in = 8'h02, rd_q, hi_in, hi_out, hi_oe, lo_in, lo_out, lo_oe, c_out, c_oe, c_pu;
	logic [31:0] pwdata = 32'h00000000, prdata;
	logic [2:0] mode_strap = MD_NORM_SINGLE;
	logic [15:0] ext_addr = 16'h0000, ext_wdata = 16'h0000, ext_rdata;
	logic pready, pslverr, ext_done;
	logic ext_word = 0, ext_ram = 0;
	logic [1:0] strb_q;
	int bad_count = 0;
	int n_tests = 0;
	always #50 pclk = ~pclk;
	bpc_port_ctrl uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mode_strap(mode_strap), .queue_status(2'b01), .high_port_pins_in(hi_in), .high_port_pins_out(hi_out),
		.high_port_pins_oe(hi_oe), .low_port_pins_in(lo_in), .low_port_pins_out(lo_out), .low_port_pins_oe(lo_oe),
		.ctrl_port_pins_in(ctrl_in), .ctrl_port_pins_out(c_out), .ctrl_port_pins_oe(c_oe), .ctrl_port_pullup(c_pu),
		.ext_req(ext_req), .ext_addr(ext_addr), .ext_write(ext_write), .ext_word(ext_word), .ext_int_ram(ext_ram),
		.ext_wdata(ext_wdata), .ext_rdata(ext_rdata), .ext_done(ext_done));
	bpc_ext_mem partner (.pclk(pclk), .hi_out(hi_out), .hi_oe(hi_oe), .lo_out(lo_out), .lo_oe(lo_oe),
		.hi_in(hi_in), .lo_in(lo_in));
	// ------------
	// shared tasks
	// ------------
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic rst(input logic [2:0] m);
		presetn <= 1'b0;
		mode_strap <= m;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			bad_count++;
			tally_and_finish();
		end
		rd_q = prdata[7:0];
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic ext_go(input logic w, input logic wd, input logic ram, input logic [15:0] a, input logic [15:0] d);
		int i;
		ext_req <= 1'b1;
		ext_write <= w;
		ext_word <= wd;
		ext_ram <= ram;
		ext_addr <= a;
		ext_wdata <= d;
		seen_a = 1'b0;
		seen_d = 1'b0;
		strb_q = 2'b10;
		i = 0;
		while (i < 24) begin
			@(posedge pclk);
			i++;
			if (hi_oe === 8'hFF && lo_oe === 8'hFF && {hi_out, lo_out} === a) seen_a = 1'b1;
			if (hi_oe === 8'hFF && lo_oe === 8'hFF && {hi_out, lo_out} === d) seen_d = 1'b1;
			if (hi_oe === 8'hFF && lo_oe === 8'hFF) strb_q = c_out[3:2];
			if (ext_done === 1'b1) ext_req <= 1'b0;
			if (ext_done === 1'b1) i = 30;
		end
		if (i != 30) begin
			bad_count++;
			tally_and_finish();
		end
		@(posedge pclk);
		if (hi_oe === 8'hFF && lo_oe === 8'hFF && {hi_out, lo_out} === d) seen_d = 1'b1;
	endtask
	// ---------
	// scenarios
	// ---------
	task automatic t_reset();
		logic [2:0] md[4] = '{MD_NORM_SINGLE, MD_SPEC_SINGLE, MD_NORM_EXP_WIDE, MD_SPEC_EXP_WIDE};
		logic [7:0] fs[4] = '{8'h90, 8'h80, 8'h80, 8'hAC};
		for (int k = 0; k < 4; k++) begin
			rst(md[k]);
			apb(1'b0, OFS_FSEL, 8'h00);
			chk("fsel reset", rd_q, fs[k]);
			chk("bus_e_clock_out drive", {7'h00, c_oe[4]}, {7'h00, ~fs[k][4]});
		end
		$display("test reset done");
	endtask
	task automatic t_gpio();
		rst(MD_NORM_SINGLE);
		apb(1'b1, OFS_HIGH_DIR, 8'hF0);
		apb(1'b1, OFS_HIGH_DATA, 8'hA5);
		apb(1'b1, OFS_LOW_DIR, 8'h0F);
		apb(1'b1, OFS_LOW_DATA, 8'h3C);
		apb(1'b1, OFS_CTRL_DIR, 8'hFF);
		@(posedge pclk);
		chk("high oe", hi_oe, 8'hF0);
		chk("high out", hi_out & hi_oe, 8'hA0);
		chk("low oe", lo_oe, 8'h0F);
		chk("low out", lo_out & lo_oe, 8'h0C);
		chk("ctrl oe", c_oe, 8'hFC);
		apb(1'b0, OFS_HIGH_DATA, 8'h00);
		chk("high read", rd_q, 8'hA0);
		apb(1'b0, OFS_LOW_DATA, 8'h00);
		chk("low read", rd_q, 8'hFC);
		apb(1'b0, OFS_CTRL_DIR, 8'h00);
		chk("ctrl dir", rd_q, 8'hFC);
		apb(1'b0, OFS_CTRL_DATA, 8'h00);
		chk("ctrl read", rd_q, 8'h02);
		apb(1'b1, OFS_CTRL_DATA, 8'hA5);
		chk("pull-up off", c_pu, 8'h01);
		apb(1'b1, OFS_MODE, 8'h10);
		@(posedge pclk);
		chk("ctrl out", c_out & c_oe, 8'hA4);
		chk("pull-up on", c_pu, 8'h03);
		apb(1'b0, 8'h20, 8'h00);
		chk("unmapped", {7'h00, err_q}, 8'h01);
		$display("test gpio done");
	endtask
	task automatic t_map();
		rst(MD_NORM_EXP_WIDE);
		apb(1'b0, OFS_HIGH_DIR, 8'h00);
		chk("exp high dir", {7'h00, err_q}, 8'h01);
		apb(1'b0, OFS_CTRL_DATA, 8'h00);
		chk("exp ctrl data", {7'h00, err_q}, 8'h00);
		apb(1'b1, OFS_MODE, 8'h08);
		apb(1'b0, OFS_CTRL_DIR, 8'h00);
		chk("emul ctrl dir", {7'h00, err_q}, 8'h01);
		rst(MD_PERIPH);
		apb(1'b0, OFS_LOW_DATA, 8'h00);
		chk("periph low data", {7'h00, err_q}, 8'h01);
		apb(1'b0, OFS_CTRL_DATA, 8'h00);
		chk("periph ctrl data", {7'h00, err_q}, 8'h01);
		apb(1'b1, OFS_FSEL, 8'hFF);
		chk("periph fsel write", {7'h00, err_q}, 8'h01);
		apb(1'b0, OFS_FSEL, 8'h00);
		chk("periph fsel read", {7'h00, err_q}, 8'h01);
		$display("test map done");
	endtask
	task automatic t_ext();
		rst(MD_SPEC_EXP_WIDE);
		chk("queue pins", {6'h00, c_out[6:5]}, 8'h01);
		ext_go(1'b1, 1'b1, 1'b0, 16'h1234, 16'hBEEF);
		chk("address on pins", {7'h00, seen_a}, 8'h01);
		chk("data on pins", {7'h00, seen_d}, 8'h01);
		chk("word write strobe", {6'h00, strb_q}, 8'h00);
		ext_go(1'b0, 1'b1, 1'b0, 16'h1256, 16'h0000);
		chk("read high half", ext_rdata[15:8], 8'h56);
		chk("read low half", ext_rdata[7:0], 8'hA9);
		chk("word read strobe", {6'h00, strb_q}, 8'h01);
		ext_go(1'b0, 1'b0, 1'b0, 16'h1301, 16'h0000);
		chk("odd byte read", ext_rdata[15:8], 8'hFE);
		chk("odd byte pad", ext_rdata[7:0], 8'h00);
		chk("odd byte strobe", {6'h00, strb_q}, 8'h01);
		ext_go(1'b0, 1'b1, 1'b1, 16'h1311, 16'h0000);
		chk("ram odd word addressed", ext_rdata[15:8], 8'hEE);
		chk("ram odd word next", ext_rdata[7:0], 8'h11);
		chk("ram odd word strobe", {6'h00, strb_q}, 8'h03);
		ext_go(1'b0, 1'b1, 1'b0, 16'h1321, 16'h0000);
		chk("split word first", ext_rdata[15:8], 8'hDE);
		chk("split word second", ext_rdata[7:0], 8'h22);
		chk("split word strobe", {6'h00, strb_q}, 8'h03);
		rst(MD_SPEC_EXP_NARROW);
		ext_go(1'b0, 1'b1, 1'b0, 16'h14A6, 16'h0000);
		chk("narrow first byte", ext_rdata[15:8], 8'hA6);
		chk("narrow second byte", ext_rdata[7:0], 8'hA7);
		$display("test external done");
	endtask
	initial begin
		t_reset();
		t_gpio();
		t_map();
		t_ext();
		tally_and_finish();
	end
endmodule
